//--- src/gstc_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef GSTC_DEFS_SVH
`define GSTC_DEFS_SVH

`define GSTC_ADDR_W 4
`define GSTC_OFF_CONTROL 4'h0
`define GSTC_OFF_GATE_SEL 4'h1
`define GSTC_OFF_CORE_IRQ 4'h2
`define GSTC_OFF_PIE 4'h3
`define GSTC_OFF_PIR 4'h4
`define GSTC_OFF_COUNT_HIGH 4'h5
`define GSTC_OFF_COUNT_LOW 4'h6
`define GSTC_OFF_CC_LOW 4'h7
`define GSTC_OFF_CC_HIGH 4'h8
`define GSTC_OFF_CC_MODE 4'h9

`define GSTC_RST_CONTROL 8'h00
`define GSTC_RST_GATE_SEL 8'h02
`define GSTC_RST_CORE_IRQ 8'h00
`define GSTC_RST_PIE 8'h00
`define GSTC_RST_PIR 8'h00
`define GSTC_RST_COUNT 16'h0000
`define GSTC_RST_CC 16'h0000
`define GSTC_COUNT_MAX 16'hffff

`define GSTC_BIT_GATE_POL 7
`define GSTC_BIT_GATE_EN 6
`define GSTC_BIT_PRESC_HI 5
`define GSTC_BIT_PRESC_LO 4
`define GSTC_BIT_LP_OSC 3
`define GSTC_BIT_SYNC_DIS 2
`define GSTC_BIT_CLK_SRC 1
`define GSTC_BIT_TIMER_ON 0
`define GSTC_BIT_GATE_SRC 1
`define GSTC_BIT_CMP_SYNC 0
`define GSTC_BIT_GIE 7
`define GSTC_BIT_PERIPHERAL_IRQ_ENABLE 6
`define GSTC_BIT_OVF 0

// instruction clock is the system clock divided by four
`define GSTC_INST_DIV_W 2
`define GSTC_INST_LAST 2'h3
`define GSTC_SYNC_COUNT 4

`endif

//--- src/gstc_pkg.sv
// types shared by the timer/counter modules
package gstc_pkg;
    typedef enum logic [1:0] {
        GSTC_CC_OFF = 2'b00,
        GSTC_CC_CAPTURE = 2'b01,
        GSTC_CC_COMPARE = 2'b10,
        GSTC_CC_SPECIAL = 2'b11
    } gstc_cc_mode_t;
    typedef logic [15:0] gstc_count_t;
endpackage

//--- src/gstc_sync.sv
// two-stage synchroniser with edge detection on the settled level
`timescale 1ns/1ps
`default_nettype none
module gstc_sync (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    gstc_sync_if.sync port
);
    logic stage_a;
    logic stage_b;
    logic stage_c;

    // stage_a feeds stage_b only; edges are taken from b and c
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage_a <= 1'b0;
            stage_b <= 1'b0;
            stage_c <= 1'b0;
        end else if (clk_en) begin
            stage_a <= port.raw;
            stage_b <= stage_a;
            stage_c <= stage_b;
        end
    end

    assign port.level = stage_b;
    assign port.rise = stage_b & ~stage_c;
    assign port.fall = ~stage_b & stage_c;
endmodule
`default_nettype wire

//--- src/gstc_sync_if.sv
// one input level before and after its synchroniser
`timescale 1ns/1ps
`default_nettype none
interface gstc_sync_if;
    logic raw;
    logic level;
    logic rise;
    logic fall;
    modport sync (input raw, output level, output rise, output fall);
    modport user (output raw, input level, input rise, input fall);
endinterface
`default_nettype wire

//--- src/gstc_timer.sv
// gated sixteen-bit timer/counter with capture/compare time base
//
// Behaviour
// RL1 - count wraps FFFFh to 0000h and sets the overflow flag
// RL2 - interrupt needs timer on, overflow, peripheral and global enables
// RL3 - software clears the overflow flag by writing zero
// RL4 - in sleep only asynchronous external counting runs; wake needs enables
// RL5 - overflow in sleep wakes; global enable then branches to vector
// RL6 - capture mode copies the count into the compare pair on event
// RL7 - compare mode fires when count equals the compare pair
// RL8 - special event clears count without setting the overflow flag
// RL9 - count byte write wins over a coincident special event
// RL10 - use synchronised counting with the special event trigger
// RL11 - synchronise comparator gate to the increment clock
// RL12 - gate polarity bit 7 selects high or low counting level
// RL13 - gate enable bit 6 makes counting follow gate while timer on
// RL14 - prescale bits 5-4 divide by 1, 2, 4 or 8
// RL15 - low-power oscillator bit 3 acts only on internal oscillator
// RL16 - sync bit 2 applies only to external source; 1 is unsynchronised (count input is always synchronised; bit 2 only allows counting in sleep)
// RL17 - source bit 1 picks external rising edges or instruction clock
// RL18 - timer-on bit 0 enables or halts counting
// RL19 - gate source select picks gate pin or comparator output
// RL20 - clear count and flag before enabling the interrupt
// RL21 - writing a count byte loads that byte immediately
// RL22 - hidden prescale counter clears on any count byte write
// RL23 - external mode needs a falling edge before the first increment
// RL24 - flag sets in the wrap cycle and ignores the enables
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "gstc_defs.svh"
module gstc_timer (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [`GSTC_ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic external_count_input,
    input wire logic low_power_osc_clock,
    input wire logic internal_oscillator,
    input wire logic gate_pin,
    input wire logic second_comparator_output,
    input wire logic capture_event,
    input wire logic sleep_mode,
    output logic irq_request,
    output logic wake_request,
    output logic vector_branch,
    output logic compare_event,
    output logic special_event,
    output logic low_power_osc_on
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] timer_one_control;
    logic [7:0] comparator_gate_select;
    logic [7:0] core_interrupt_control;
    logic [7:0] peripheral_interrupt_enable;
    logic [7:0] peripheral_interrupt_flags;
    gstc_pkg::gstc_count_t count;
    gstc_pkg::gstc_count_t capture_compare;
    gstc_pkg::gstc_cc_mode_t cc_mode;
    logic [2:0] prescale_count;
    logic [`GSTC_INST_DIV_W-1:0] inst_div;
    logic armed;
    logic comp_held;
    logic match_prev;
    logic special_pend;

    ////////////////////////////////////////////////////////////////////////
    // synchronisers: 0 count input, 1 gate pin, 2 comparator, 3 capture
    logic [`GSTC_SYNC_COUNT-1:0] pin_raw;
    logic [`GSTC_SYNC_COUNT-1:0] pin_level;
    logic [`GSTC_SYNC_COUNT-1:0] pin_rise;
    logic [`GSTC_SYNC_COUNT-1:0] pin_fall;
    wire lp_osc_sel;

    // source switch ahead of the synchroniser may cost one edge
    assign lp_osc_sel = timer_one_control[`GSTC_BIT_LP_OSC]
        & internal_oscillator; // RL15
    assign pin_raw[0] = lp_osc_sel ? low_power_osc_clock
        : external_count_input;
    assign pin_raw[1] = gate_pin;
    assign pin_raw[2] = second_comparator_output;
    assign pin_raw[3] = capture_event;

    gstc_sync_if sif[`GSTC_SYNC_COUNT] ();
    genvar gi;
    generate
        for (gi = 0; gi < `GSTC_SYNC_COUNT; gi++) begin : g_sync
            assign sif[gi].raw = pin_raw[gi];
            assign pin_level[gi] = sif[gi].level;
            assign pin_rise[gi] = sif[gi].rise;
            assign pin_fall[gi] = sif[gi].fall;
            gstc_sync u_sync (
                .clock(clock),
                .rst_n(rst_n),
                .clk_en(clk_en),
                .port(sif[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // decode
    wire wr_control = wr_stb & (addr == `GSTC_OFF_CONTROL);
    wire wr_gate_sel = wr_stb & (addr == `GSTC_OFF_GATE_SEL);
    wire wr_core_irq = wr_stb & (addr == `GSTC_OFF_CORE_IRQ);
    wire wr_pie = wr_stb & (addr == `GSTC_OFF_PIE);
    wire wr_pir = wr_stb & (addr == `GSTC_OFF_PIR);
    wire wr_high = wr_stb & (addr == `GSTC_OFF_COUNT_HIGH);
    wire wr_low = wr_stb & (addr == `GSTC_OFF_COUNT_LOW);
    wire wr_cc_low = wr_stb & (addr == `GSTC_OFF_CC_LOW);
    wire wr_cc_high = wr_stb & (addr == `GSTC_OFF_CC_HIGH);
    wire wr_cc_mode = wr_stb & (addr == `GSTC_OFF_CC_MODE);
    wire count_write = wr_high | wr_low;

    ////////////////////////////////////////////////////////////////////////
    // increment path
    wire timer_on = timer_one_control[`GSTC_BIT_TIMER_ON];
    wire gate_en = timer_one_control[`GSTC_BIT_GATE_EN];
    wire gate_pol = timer_one_control[`GSTC_BIT_GATE_POL];
    wire ext_src = timer_one_control[`GSTC_BIT_CLK_SRC];
    wire sync_off = timer_one_control[`GSTC_BIT_SYNC_DIS];
    wire [1:0] presc_sel = timer_one_control[`GSTC_BIT_PRESC_HI:
        `GSTC_BIT_PRESC_LO];
    wire async_mode = ext_src & sync_off; // RL16
    wire inst_tick = (inst_div == `GSTC_INST_LAST);
    // external edges only count once a falling edge has been seen
    wire ext_tick = pin_rise[0] & armed; // RL23
    wire src_tick = ext_src ? ext_tick : inst_tick; // RL17
    wire [2:0] presc_mask = 3'h7 >> (2'd3 - presc_sel);
    wire presc_done = ((prescale_count & presc_mask) == presc_mask); // RL14
    wire comp_level = comparator_gate_select[`GSTC_BIT_CMP_SYNC]
        ? comp_held : pin_level[2];
    wire gate_level = comparator_gate_select[`GSTC_BIT_GATE_SRC]
        ? pin_level[1] : comp_level; // RL19
    wire gate_open = ~gate_en | (gate_level == gate_pol); // RL12 RL13
    // system clock stands still in sleep unless counting asynchronously
    wire clock_alive = ~sleep_mode | async_mode; // RL4
    wire running = timer_on & gate_open & clock_alive; // RL18
    wire inc = running & src_tick & presc_done;
    wire wrap = inc & (count == `GSTC_COUNT_MAX);
    wire overflow_set = wrap & ~count_write & ~special_pend; // RL1 RL8 RL24
    wire cc_match = (count == capture_compare);
    wire is_compare = (cc_mode == gstc_pkg::GSTC_CC_COMPARE)
        | (cc_mode == gstc_pkg::GSTC_CC_SPECIAL);
    wire cc_hit = is_compare & cc_match & ~match_prev; // RL7
    wire cap_take = (cc_mode == gstc_pkg::GSTC_CC_CAPTURE) & pin_rise[3];
    wire special_clear = special_pend & ~count_write; // RL9

    ////////////////////////////////////////////////////////////////////////
    // next count: byte write, then special clear, then increment
    gstc_pkg::gstc_count_t next_count;
    always_comb begin
        next_count = count;
        if (count_write) begin
            if (wr_high) begin
                next_count[15:8] = wdata; // RL21
            end
            if (wr_low) begin
                next_count[7:0] = wdata; // RL21
            end
        end else if (special_pend) begin
            next_count = `GSTC_RST_COUNT; // RL8
        end else if (inc) begin
            next_count = 16'(count + 16'h0001); // RL1
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= `GSTC_RST_COUNT;
        end else if (clk_en) begin
            count <= next_count;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prescale_count <= 3'h0;
            inst_div <= `GSTC_INST_DIV_W'(0);
        end else if (clk_en) begin
            inst_div <= `GSTC_INST_DIV_W'(inst_div + 1'b1);
            if (count_write) begin
                prescale_count <= 3'h0; // RL22
            end else if (running & src_tick) begin
                prescale_count <= presc_done ? 3'h0
                    : 3'(prescale_count + 3'h1);
            end
        end
    end

    // arming drops on enable, disable or count write
    wire disarm = count_write | (wr_control
        & (wdata[`GSTC_BIT_TIMER_ON] != timer_on));
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            armed <= 1'b0;
        end else if (clk_en) begin
            if (disarm) begin
                armed <= 1'b0; // RL23
            end else if (pin_fall[0]) begin
                armed <= 1'b1;
            end
        end
    end

    // comparator follows the increment clock when resync is on
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            comp_held <= 1'b0;
        end else if (clk_en && src_tick) begin
            comp_held <= pin_level[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timer_one_control <= `GSTC_RST_CONTROL;
            comparator_gate_select <= `GSTC_RST_GATE_SEL;
            core_interrupt_control <= `GSTC_RST_CORE_IRQ;
            peripheral_interrupt_enable <= `GSTC_RST_PIE;
            cc_mode <= gstc_pkg::GSTC_CC_OFF;
        end else if (clk_en) begin
            if (wr_control) begin
                timer_one_control <= wdata;
            end
            if (wr_gate_sel) begin
                comparator_gate_select <= {6'h00, wdata[1:0]};
            end
            if (wr_core_irq) begin
                core_interrupt_control <= wdata;
            end
            if (wr_pie) begin
                peripheral_interrupt_enable <= wdata;
            end
            if (wr_cc_mode) begin
                cc_mode <= gstc_pkg::gstc_cc_mode_t'(wdata[1:0]);
            end
        end
    end

    // overflow set beats a clearing write in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            peripheral_interrupt_flags <= `GSTC_RST_PIR;
        end else if (clk_en) begin
            if (wr_pir) begin
                peripheral_interrupt_flags <= wdata; // RL3
            end
            if (overflow_set) begin
                peripheral_interrupt_flags[`GSTC_BIT_OVF] <= 1'b1; // RL24
            end
        end
    end

    // capture outranks a software write to the pair
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            capture_compare <= `GSTC_RST_CC;
        end else if (clk_en) begin
            if (cap_take) begin
                capture_compare <= count; // RL6
            end else begin
                if (wr_cc_low) begin
                    capture_compare[7:0] <= wdata;
                end
                if (wr_cc_high) begin
                    capture_compare[15:8] <= wdata;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // compare event and special trigger
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            match_prev <= 1'b0;
            special_pend <= 1'b0;
            compare_event <= 1'b0;
            special_event <= 1'b0;
        end else if (clk_en) begin
            match_prev <= cc_match;
            compare_event <= cc_hit; // RL7
            special_pend <= cc_hit & (cc_mode == gstc_pkg::GSTC_CC_SPECIAL);
            special_event <= special_clear;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt and wake
    wire ovf_flag = peripheral_interrupt_flags[`GSTC_BIT_OVF];
    wire ovf_en = peripheral_interrupt_enable[`GSTC_BIT_OVF];
    wire peripheral_irq_enable = core_interrupt_control[`GSTC_BIT_PERIPHERAL_IRQ_ENABLE];
    wire global_irq_enable = core_interrupt_control[`GSTC_BIT_GIE];
    wire next_irq = timer_on & ovf_en & ovf_flag & peripheral_irq_enable & global_irq_enable; // RL2
    wire next_wake = sleep_mode & timer_on & ovf_en & ovf_flag & peripheral_irq_enable; // RL4

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_request <= 1'b0;
            wake_request <= 1'b0;
            vector_branch <= 1'b0;
            low_power_osc_on <= 1'b0;
        end else if (clk_en) begin
            irq_request <= next_irq;
            wake_request <= next_wake; // RL5
            vector_branch <= next_wake & global_irq_enable; // RL5
            low_power_osc_on <= lp_osc_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port, unmapped offsets read zero
    logic [7:0] read_mux;
    always_comb begin
        case (addr)
            `GSTC_OFF_CONTROL: read_mux = timer_one_control;
            `GSTC_OFF_GATE_SEL: read_mux = comparator_gate_select;
            `GSTC_OFF_CORE_IRQ: read_mux = core_interrupt_control;
            `GSTC_OFF_PIE: read_mux = peripheral_interrupt_enable;
            `GSTC_OFF_PIR: read_mux = peripheral_interrupt_flags;
            `GSTC_OFF_COUNT_HIGH: read_mux = count[15:8];
            `GSTC_OFF_COUNT_LOW: read_mux = count[7:0];
            `GSTC_OFF_CC_LOW: read_mux = capture_compare[7:0];
            `GSTC_OFF_CC_HIGH: read_mux = capture_compare[15:8];
            `GSTC_OFF_CC_MODE: read_mux = {6'h00, cc_mode};
            default: read_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (clk_en) begin
            rdata <= rd_stb ? read_mux : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    wrap_sets_flag_a: assert property (clk_en && overflow_set |=> // RL1
        count == 16'h0000 && peripheral_interrupt_flags[0])
        else $error("wrap did not zero count and set flag");
    irq_needs_gie_a: assert property (clk_en && !global_irq_enable |=> !irq_request) // RL2
        else $error("interrupt raised without global enable");
    flag_sticky_a: assert property (clk_en && ovf_flag && !wr_pir |=> // RL24
        peripheral_interrupt_flags[0])
        else $error("overflow flag dropped without a write");
    sleep_freeze_a: assert property (clk_en && sleep_mode && !async_mode // RL4
        && !count_write && !special_pend |=> $stable(count))
        else $error("count moved in sleep outside async mode");
    capture_copy_a: assert property (clk_en && cap_take |=> // RL6
        capture_compare == $past(count))
        else $error("capture did not copy the count");
    special_clear_a: assert property (clk_en && special_clear && !wr_pir // RL8
        |=> count == 16'h0000 && $stable(peripheral_interrupt_flags[0]))
        else $error("special event did not clear quietly");
    write_wins_a: assert property (clk_en && wr_low && special_pend |=> // RL9
        count[7:0] == $past(wdata))
        else $error("special event beat a count write");
    presc_clear_a: assert property (clk_en && count_write |=> // RL22
        prescale_count == 3'h0)
        else $error("prescaler not cleared by count write");
    gate_block_a: assert property (clk_en && timer_on && gate_en // RL13
        && gate_level != gate_pol && !count_write && !special_pend
        |=> $stable(count))
        else $error("count advanced with gate closed");
    arm_drop_a: assert property (clk_en && count_write |=> !armed) // RL23
        else $error("external edge armed after count write");
endmodule
`default_nettype wire

//--- test/gstc_far.sv
// far-side model: count pin, gate sources and capture strobe
`timescale 1ns/1ps
`default_nettype none
module gstc_far (
    output var logic ext_pin,
    output var logic gate_pin,
    output var logic cmp_out,
    output var logic cap_evt
);
    initial begin
        ext_pin = 1'b1;
        gate_pin = 1'b0;
        cmp_out = 1'b0;
        cap_evt = 1'b0;
    end
    // odd delays put each ext_pin rise off the system clock edges; its falls, 180 ns apart, keep the phase of the call
    task automatic pulses(input int n);
        repeat (n) begin
            ext_pin = 1'b0;
            #87;
            ext_pin = 1'b1;
            #93;
        end
    endtask
    task automatic park(input logic v);
        ext_pin = v;
        #87;
    endtask
    task automatic gates(input logic pin, input logic cmp);
        gate_pin = pin;
        cmp_out = cmp;
    endtask
    task automatic capture();
        cap_evt = 1'b1;
        #97;
        cap_evt = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the gated sixteen-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
`include "gstc_defs.svh"
module tb;
    logic clock, rst_n, wr_stb, rd_stb, int_osc, sleep_mode;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, d, h;
    logic irq, wake, vect, cmp_ev, spc_ev, lp_on, ext, gp, co, cap;
    logic [31:0] seed;
    int err_count, n_tests, k, t, n_spc;
    gstc_timer u_dut (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .external_count_input(ext),
        .low_power_osc_clock(1'b0), .internal_oscillator(int_osc),
        .gate_pin(gp), .second_comparator_output(co), .capture_event(cap),
        .sleep_mode(sleep_mode), .irq_request(irq), .wake_request(wake),
        .vector_branch(vect), .compare_event(cmp_ev),
        .special_event(spc_ev), .low_power_osc_on(lp_on));
    gstc_far u_far (.ext_pin(ext), .gate_pin(gp), .cmp_out(co),
        .cap_evt(cap));
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // instruction clock is a quarter of the system clock
    function automatic int ticks(input int cyc, input int ps);
        return cyc >> (2 + ps);
    endfunction
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic settle();
        @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // free-running instruction clock phase leaves one tick of slack
    task automatic near(input logic [15:0] got, input int exp);
        chk((got + 16'h0001 - exp[15:0] <= 16'h0002) ? exp[15:0] : got,
            exp[15:0]);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wait_ev(input bit spc, output int n);
        n = 0;
        do begin
            settle();
            n++;
            if (n > 1000) begin
                err_count++;
                report_and_stop();
            end
        end while ((spc ? spc_ev : cmp_ev) !== 1'b1);
    endtask
    always @(posedge clock) begin
        if (spc_ev === 1'b1) begin
            n_spc <= n_spc + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        rst_n = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        int_osc = 1'b0;
        sleep_mode = 1'b0;
        seed = 32'h87f4_9abe;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        for (k = 0; k < 8; k++) begin
            rd(k == 7 ? 4'hf : k[3:0]);
            chk(d, k == 1 ? 16'h0002 : 16'h0000);
        end
        for (k = 0; k < 4; k++) begin
            wr(`GSTC_OFF_COUNT_HIGH, 8'h00);
            wr(`GSTC_OFF_COUNT_LOW, 8'h00);
            wr(`GSTC_OFF_CONTROL, {2'b00, k[1:0], 4'b0001});
            repeat (24 << k) @(posedge clock);
            wr(`GSTC_OFF_CONTROL, 8'h00);
            rd(`GSTC_OFF_COUNT_LOW);
            near(d, ticks((24 << k) + 2, k));
            h = d;
            repeat (20) @(posedge clock);
            rd(`GSTC_OFF_COUNT_LOW);
            chk(d, h);
        end
        wr(`GSTC_OFF_PIR, 8'h00);
        wr(`GSTC_OFF_COUNT_HIGH, 8'hff);
        wr(`GSTC_OFF_COUNT_LOW, 8'hf8);
        wr(`GSTC_OFF_CONTROL, 8'h01);
        repeat (40) @(posedge clock);
        wr(`GSTC_OFF_CONTROL, 8'h00);
        rd(`GSTC_OFF_COUNT_HIGH);
        chk(d, 16'h0000);
        rd(`GSTC_OFF_PIR);
        chk(d, 16'h0001);
        wr(`GSTC_OFF_PIE, 8'h01);
        wr(`GSTC_OFF_CORE_IRQ, 8'hc0);
        settle();
        chk(irq, 1'b0);
        wr(`GSTC_OFF_CONTROL, 8'h01);
        settle();
        chk(irq, 1'b1);
        wr(`GSTC_OFF_CORE_IRQ, 8'h40);
        settle();
        chk(irq, 1'b0);
        wr(`GSTC_OFF_CORE_IRQ, 8'hc0);
        wr(`GSTC_OFF_PIR, 8'h00);
        settle();
        chk(irq, 1'b0);
        int_osc <= 1'b1;
        wr(`GSTC_OFF_CONTROL, 8'h08);
        settle();
        chk(lp_on, 1'b1);
        int_osc <= 1'b0;
        settle();
        settle();
        chk(lp_on, 1'b0);
        seed = lfsr(seed);
        k = 3 + seed[2:0];
        u_far.park(1'b0);
        wr(`GSTC_OFF_CONTROL, 8'h03);
        wr(`GSTC_OFF_COUNT_HIGH, 8'h00);
        wr(`GSTC_OFF_COUNT_LOW, 8'h00);
        u_far.pulses(k);
        repeat (8) @(posedge clock);
        rd(`GSTC_OFF_COUNT_LOW);
        chk(d, k[15:0] - 16'h0001);
        wr(`GSTC_OFF_CONTROL, 8'h01);
        sleep_mode <= 1'b1;
        rd(`GSTC_OFF_COUNT_LOW);
        h = d;
        repeat (40) @(posedge clock);
        rd(`GSTC_OFF_COUNT_LOW);
        chk(d, h);
        u_far.park(1'b1);
        wr(`GSTC_OFF_COUNT_HIGH, 8'hff);
        wr(`GSTC_OFF_COUNT_LOW, 8'hff);
        wr(`GSTC_OFF_CONTROL, 8'h07);
        u_far.pulses(1);
        repeat (8) @(posedge clock);
        settle();
        chk(wake, 1'b1);
        chk(vect, 1'b1);
        sleep_mode <= 1'b0;
        wr(`GSTC_OFF_CORE_IRQ, 8'h00);
        for (k = 0; k < 4; k++) begin
            wr(`GSTC_OFF_GATE_SEL, {6'b0, k[1], !k[1]});
            u_far.gates(k[0] ^ k[1], !(k[0] ^ k[1]));
            wr(`GSTC_OFF_CONTROL, {k[0], 6'b10_0000, 1'b1});
            wr(`GSTC_OFF_COUNT_HIGH, 8'h00);
            wr(`GSTC_OFF_COUNT_LOW, 8'h00);
            repeat (40) @(posedge clock);
            rd(`GSTC_OFF_COUNT_LOW);
            chk(d, 16'h0000);
            u_far.gates(!(k[0] ^ k[1]), k[0] ^ k[1]);
            repeat (8) @(posedge clock);
            wr(`GSTC_OFF_COUNT_LOW, 8'h00);
            repeat (40) @(posedge clock);
            rd(`GSTC_OFF_COUNT_LOW);
            near(d, 10);
        end
        wr(`GSTC_OFF_CONTROL, 8'h00);
        wr(`GSTC_OFF_CC_MODE, 8'h01);
        seed = lfsr(seed);
        wr(`GSTC_OFF_COUNT_HIGH, seed[15:8]);
        wr(`GSTC_OFF_COUNT_LOW, seed[7:0]);
        u_far.capture();
        repeat (8) @(posedge clock);
        rd(`GSTC_OFF_CC_HIGH);
        h = d;
        rd(`GSTC_OFF_CC_LOW);
        chk({h, d}, seed[15:0]);
        for (k = 2; k < 4; k++) begin
            seed = lfsr(seed);
            h = {3'b000, seed[4:0]} + 8'h08;
            wr(`GSTC_OFF_CONTROL, 8'h00);
            wr(`GSTC_OFF_CC_MODE, k[7:0]);
            wr(`GSTC_OFF_CC_HIGH, 8'h00);
            wr(`GSTC_OFF_CC_LOW, h);
            wr(`GSTC_OFF_PIR, 8'h00);
            wr(`GSTC_OFF_COUNT_HIGH, 8'h00);
            wr(`GSTC_OFF_COUNT_LOW, 8'h00);
            n_spc = 0;
            wr(`GSTC_OFF_CONTROL, 8'h01);
            wait_ev(1'b0, t);
            if (k == 2) begin
                repeat (4) settle();
                chk(n_spc[15:0], 16'h0000);
            end else begin
                wait_ev(1'b1, t);
                wait_ev(1'b1, t);
                chk(t[15:0], {6'b0, h, 2'b00});
                rd(`GSTC_OFF_PIR);
                chk(d, 16'h0000);
                // second write lands while the match clear is pending
                wr(`GSTC_OFF_CONTROL, 8'h00);
                wr(`GSTC_OFF_COUNT_LOW, h);
                wr(`GSTC_OFF_COUNT_LOW, 8'h5a);
                rd(`GSTC_OFF_COUNT_LOW);
                chk(d, 16'h005a);
            end
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
